//--- bsr_defs.svh
`ifndef BSR_DEFS_SVH
`define BSR_DEFS_SVH
// Functional notes
// - Every I/O block has three scan cells: input, output, 3-state.
// - Non-I/O-block pins carry only an input or an output cell; TDO carries output and 3-state.
// - Config clear, config clock and done pins have no scan cells.
// - External test Capture-DR loads in, out and 3-state of all I/O blocks.
// - Cell 0 is TDO 3-state, cell 1 TDO output, last the trailer.
// - Bypass is one flip-flop from test data in to test data out.
// - Two user selects; matching user scan-out feeds test data out.
// - Data register clock is given to user logic.
// - User idle output is NAND of test clock and Run-Test/Idle.
// - Codes 000 extest, 001 sample, 010/011 user, 110 reserved, 111 bypass.
// - 100 readback data out; 101 config daisy out with I/O disabled.
// - Each I/O group shifts 3-state, then output, then input.
// - TAP pin output buffers are off while scan selected; inputs direct.
// - Primary clock pads go straight to the core, never scan data.
// - A clock pad used as plain signal is replaceable like any I/O.
// - Pulls stay active in scan; all pulled up before/during config.
// - Chain starts top-right at TDO, goes round counter-clockwise.
// - Without kept scan after config, TAP pins become user pins.
// - 16-state TAP controller, instruction register, selectable data regs.
// - Public instructions before config; after only if design keeps scan.
// - Reset, update and shift state decodes go to user logic.

// Chain layout, position 0 nearest test data out
`define BSR_NUM_IO      4
`define BSR_CLK_IO      0
`define BSR_POS_TDO_T   0
`define BSR_POS_TDO_O   1
`define BSR_POS_IO_BASE 2
`define BSR_POS_IN_ONLY 14
`define BSR_POS_OUT_ONLY 15
`define BSR_POS_TRAILER 16
`define BSR_CHAIN_LEN   17
`define BSR_IR_CAPTURE  3'h1

// Register map and fields
`define BSR_ADDR_CTRL   4'h0
`define BSR_ADDR_STATUS 4'h4
`define BSR_CTRL_RESET  4'h0
`define BSR_CTRL_DONE   0
`define BSR_CTRL_KEEP   1
`define BSR_CTRL_CLKPAD 2
`define BSR_CTRL_PULLDN 3
`define BSR_STAT_STATE  0
`define BSR_STAT_INSTR  4
`define BSR_STAT_TAPEN  7
`define BSR_RESP_OKAY   2'h0
`define BSR_RESP_SLVERR 2'h2
`endif

//--- bsr_jtag_host.sv
`timescale 1ns/100ps
// ==========
// Far-side test controller; tck rests low between frames
module bsr_jtag_host (
	output logic     tck,
	output logic     tms,
	output logic     tdi,
	input wire logic tdo
);
	// Mode select high and a still clock keep the port in reset
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	// One bit per 400 ns; tdo read late in the high phase, before it moves
	task automatic xfer(input logic [31:0] ms, di, input int n,
		output logic [31:0] dq);
		dq = '0;
		for (int i = 0; i < n; i++) begin
			tms = ms[i];
			tdi = di[i];
			#200 tck = 1'h1;
			#190 dq[i] = tdo;
			#10 tck = 1'h0;
		end
		#100 tdi = ~tdi; // Nothing may lean on a stale data level
	endtask
endmodule

//--- bsr_pkg.sv
package bsr_pkg;
	typedef enum logic [3:0] {
		TAP_RESET      = 4'h0,
		TAP_IDLE       = 4'h1,
		TAP_SEL_DR     = 4'h2,
		TAP_CAPTURE_DR = 4'h3,
		TAP_SHIFT_DR   = 4'h4,
		TAP_EXIT1_DR   = 4'h5,
		TAP_PAUSE_DR   = 4'h6,
		TAP_EXIT2_DR   = 4'h7,
		TAP_UPDATE_DR  = 4'h8,
		TAP_SEL_IR     = 4'h9,
		TAP_CAPTURE_IR = 4'ha,
		TAP_SHIFT_IR   = 4'hb,
		TAP_EXIT1_IR   = 4'hc,
		TAP_PAUSE_IR   = 4'hd,
		TAP_EXIT2_IR   = 4'he,
		TAP_UPDATE_IR  = 4'hf
	} bsr_tap_state_t;

	typedef enum logic [2:0] {
		INS_EXTEST    = 3'h0,
		INS_SAMPLE    = 3'h1,
		INS_USER_ONE  = 3'h2,
		INS_USER_TWO  = 3'h3,
		INS_READBACK  = 3'h4,
		INS_CONFIGURE = 3'h5,
		INS_RESERVED  = 3'h6,
		INS_BYPASS    = 3'h7
	} bsr_instr_t;

	// Update stage of one I/O block, in shift order
	typedef struct packed {
		logic tri_en;
		logic dout;
		logic din;
	} bsr_cell_t;
endpackage

//--- bsr_tap_ctrl.sv
`timescale 1ns/100ps
module bsr_tap_ctrl (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             tck_rise,
	input  wire logic             tms,
	input  wire logic             force_reset,
	output bsr_pkg::bsr_tap_state_t state_r
);
	bsr_pkg::bsr_tap_state_t state_nxt;

	// =========================================
	// Sixteen-state walk, one step per test clock rise
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bsr_pkg::TAP_RESET:      state_nxt = tms ? bsr_pkg::TAP_RESET
				: bsr_pkg::TAP_IDLE;
			bsr_pkg::TAP_IDLE:       state_nxt = tms ? bsr_pkg::TAP_SEL_DR
				: bsr_pkg::TAP_IDLE;
			bsr_pkg::TAP_SEL_DR:     state_nxt = tms ? bsr_pkg::TAP_SEL_IR
				: bsr_pkg::TAP_CAPTURE_DR;
			bsr_pkg::TAP_CAPTURE_DR: state_nxt = tms ? bsr_pkg::TAP_EXIT1_DR
				: bsr_pkg::TAP_SHIFT_DR;
			bsr_pkg::TAP_SHIFT_DR:   state_nxt = tms ? bsr_pkg::TAP_EXIT1_DR
				: bsr_pkg::TAP_SHIFT_DR;
			bsr_pkg::TAP_EXIT1_DR:   state_nxt = tms ? bsr_pkg::TAP_UPDATE_DR
				: bsr_pkg::TAP_PAUSE_DR;
			bsr_pkg::TAP_PAUSE_DR:   state_nxt = tms ? bsr_pkg::TAP_EXIT2_DR
				: bsr_pkg::TAP_PAUSE_DR;
			bsr_pkg::TAP_EXIT2_DR:   state_nxt = tms ? bsr_pkg::TAP_UPDATE_DR
				: bsr_pkg::TAP_SHIFT_DR;
			bsr_pkg::TAP_UPDATE_DR:  state_nxt = tms ? bsr_pkg::TAP_SEL_DR
				: bsr_pkg::TAP_IDLE;
			bsr_pkg::TAP_SEL_IR:     state_nxt = tms ? bsr_pkg::TAP_RESET
				: bsr_pkg::TAP_CAPTURE_IR;
			bsr_pkg::TAP_CAPTURE_IR: state_nxt = tms ? bsr_pkg::TAP_EXIT1_IR
				: bsr_pkg::TAP_SHIFT_IR;
			bsr_pkg::TAP_SHIFT_IR:   state_nxt = tms ? bsr_pkg::TAP_EXIT1_IR
				: bsr_pkg::TAP_SHIFT_IR;
			bsr_pkg::TAP_EXIT1_IR:   state_nxt = tms ? bsr_pkg::TAP_UPDATE_IR
				: bsr_pkg::TAP_PAUSE_IR;
			bsr_pkg::TAP_PAUSE_IR:   state_nxt = tms ? bsr_pkg::TAP_EXIT2_IR
				: bsr_pkg::TAP_PAUSE_IR;
			bsr_pkg::TAP_EXIT2_IR:   state_nxt = tms ? bsr_pkg::TAP_UPDATE_IR
				: bsr_pkg::TAP_SHIFT_IR;
			bsr_pkg::TAP_UPDATE_IR:  state_nxt = tms ? bsr_pkg::TAP_SEL_DR
				: bsr_pkg::TAP_IDLE;
			default:                 state_nxt = bsr_pkg::TAP_RESET;
		endcase
	end

	// A disabled port is parked in reset so stray pin activity is harmless
	always_ff @(posedge aclk) begin
		if (!aresetn || force_reset)
			state_r <= bsr_pkg::TAP_RESET;
		else if (tck_rise)
			state_r <= state_nxt;
	end
endmodule

//--- bsr_top.sv
`timescale 1ns/100ps
`include "bsr_defs.svh"
module bsr_top (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// AXI4-Lite register slave
	input  wire logic [3:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [3:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Test access port pins
	input  wire logic                     tck_pin,
	input  wire logic                     tms_pin,
	input  wire logic                     tdi_pin,
	output logic                          tdo_pin_out,
	output logic                          tdo_pin_oe,
	input  wire logic [2:0]               tap_pin_user_oe,
	output logic [2:0]                    tap_pin_oe,
	output logic [2:0]                    tap_pin_user_in,
	// I/O blocks in chain order, index 0 at the top-right corner
	input  wire logic [`BSR_NUM_IO-1:0]   io_pad_in,
	output logic [`BSR_NUM_IO-1:0]        io_pad_out,
	output logic [`BSR_NUM_IO-1:0]        io_pad_oe,
	output logic [`BSR_NUM_IO-1:0]        io_pull_up,
	output logic [`BSR_NUM_IO-1:0]        io_pull_dn,
	input  wire logic [`BSR_NUM_IO-1:0]   io_core_out,
	input  wire logic [`BSR_NUM_IO-1:0]   io_core_oe,
	output logic [`BSR_NUM_IO-1:0]        io_core_in,
	// Single-cell pins and primary clock pad
	input  wire logic                     in_only_pad,
	output logic                          in_only_core,
	input  wire logic                     out_only_core,
	output logic                          out_only_pad,
	input  wire logic                     gclk_pad,
	output logic                          gclk_core,
	// User scan hooks
	output logic                          user_select_one,
	output logic                          user_select_two,
	input  wire logic                     user_scan_out_one,
	input  wire logic                     user_scan_out_two,
	output logic                          user_dr_clock,
	output logic                          user_idle_gate,
	output logic                          user_reset,
	output logic                          user_update,
	output logic                          user_shift,
	output logic                          user_tdi,
	// Configuration engine hooks
	input  wire logic                     readback_data,
	input  wire logic                     config_dout,
	output logic                          readback_sel,
	output logic                          config_sel
);
	localparam int NIO = `BSR_NUM_IO;
	localparam int SW  = NIO + 5;
	localparam int CL  = `BSR_CHAIN_LEN;

	// Boundary register instructions share the shift chain
	function automatic logic uses_chain(input bsr_pkg::bsr_instr_t i);
		return (i == bsr_pkg::INS_EXTEST) || (i == bsr_pkg::INS_SAMPLE);
	endfunction

	// =========================================
	// Pin synchronisers
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;
	logic          tck_d_r;
	logic          tck_s;
	logic          tms_s;
	logic          tdi_s;
	logic          gclk_s;
	logic          in_only_s;
	logic [NIO-1:0] pad_in_s;
	logic          tck_rise;
	logic          tck_fall;

	// Two stages for every asynchronous pin; only stage two is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			tck_d_r <= 1'b0;
		end else begin
			sync1_r <= {io_pad_in, in_only_pad, gclk_pad, tdi_pin, tms_pin,
				tck_pin};
			sync2_r <= sync1_r;
			tck_d_r <= sync2_r[0];
		end
	end

	assign tck_s     = sync2_r[0];
	assign tms_s     = sync2_r[1];
	assign tdi_s     = sync2_r[2];
	assign gclk_s    = sync2_r[3];
	assign in_only_s = sync2_r[4];
	assign pad_in_s  = sync2_r[SW-1:5];
	assign tck_rise  = tck_s & ~tck_d_r;
	assign tck_fall  = ~tck_s & tck_d_r;

	// =========================================
	// Control register and port enable
	logic [3:0] ctrl_r;
	logic       cfg_done;
	logic       scan_keep;
	logic       tap_en;

	assign cfg_done  = ctrl_r[`BSR_CTRL_DONE];
	assign scan_keep = ctrl_r[`BSR_CTRL_KEEP];
	// Before configuration the port always works; after, only if kept
	assign tap_en    = ~cfg_done | scan_keep;

	// =========================================
	// TAP controller
	bsr_pkg::bsr_tap_state_t state;

	bsr_tap_ctrl u_tap (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.tck_rise    (tck_rise),
		.tms         (tms_s),
		.force_reset (~tap_en),
		.state_r     (state)
	);

	// =========================================
	// Instruction register
	logic [2:0]          ir_shift_r;
	bsr_pkg::bsr_instr_t instr_r;
	bsr_pkg::bsr_instr_t instr;

	// Reserved code falls back to bypass
	assign instr = (instr_r == bsr_pkg::INS_RESERVED) ?
		bsr_pkg::INS_BYPASS : instr_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || state == bsr_pkg::TAP_RESET) begin
			ir_shift_r <= `BSR_IR_CAPTURE;
			instr_r    <= bsr_pkg::INS_BYPASS;
		end else if (tck_rise) begin
			if (state == bsr_pkg::TAP_CAPTURE_IR)
				ir_shift_r <= `BSR_IR_CAPTURE;
			else if (state == bsr_pkg::TAP_SHIFT_IR)
				ir_shift_r <= {tdi_s, ir_shift_r[2:1]};
		end else if (tck_fall && state == bsr_pkg::TAP_UPDATE_IR) begin
			instr_r <= bsr_pkg::bsr_instr_t'(ir_shift_r);
		end
	end

	// =========================================
	// Boundary scan chain and bypass
	logic [CL-1:0]       chain_r;
	logic [CL-1:0]       capture;
	logic                bypass_r;
	bsr_pkg::bsr_cell_t  upd_r [NIO];
	logic                upd_in_only_r;
	logic                upd_out_only_r;
	logic                upd_tdo_t_r;
	logic                upd_tdo_o_r;

	// Snapshot of TDO, I/O and single-cell pins; TAP inputs, clock pad and config pins have no place here
	always_comb begin
		capture = '0;
		capture[`BSR_POS_TDO_T] = tdo_pin_oe;
		capture[`BSR_POS_TDO_O] = tdo_pin_out;
		for (int k = 0; k < NIO; k++) begin
			capture[`BSR_POS_IO_BASE + 3*k]     = io_pad_oe[k];
			capture[`BSR_POS_IO_BASE + 3*k + 1] = io_pad_out[k];
			capture[`BSR_POS_IO_BASE + 3*k + 2] = pad_in_s[k];
		end
		capture[`BSR_POS_IN_ONLY]  = in_only_s;
		capture[`BSR_POS_OUT_ONLY] = out_only_pad;
		capture[`BSR_POS_TRAILER]  = 1'b0;
	end

	// Data enters at the trailer end and leaves at cell 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chain_r <= '0;
		end else if (tck_rise && uses_chain(instr)) begin
			if (state == bsr_pkg::TAP_CAPTURE_DR)
				chain_r <= capture;
			else if (state == bsr_pkg::TAP_SHIFT_DR)
				chain_r <= {tdi_s, chain_r[CL-1:1]};
		end
	end

	// One-stage pass-through register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bypass_r <= 1'b0;
		else if (tck_rise && state == bsr_pkg::TAP_CAPTURE_DR)
			bypass_r <= 1'b0;
		else if (tck_rise && state == bsr_pkg::TAP_SHIFT_DR)
			bypass_r <= tdi_s;
	end

	// Update stage; preload is allowed under sample as well
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < NIO; k++)
				upd_r[k] <= '0;
			upd_in_only_r  <= 1'b0;
			upd_out_only_r <= 1'b0;
			upd_tdo_t_r    <= 1'b0;
			upd_tdo_o_r    <= 1'b0;
		end else if (tck_fall && state == bsr_pkg::TAP_UPDATE_DR
			&& uses_chain(instr)) begin
			// The struct keeps 3-state on top; the chain keeps it lowest
			for (int k = 0; k < NIO; k++)
				upd_r[k] <= {chain_r[`BSR_POS_IO_BASE + 3*k],
					chain_r[`BSR_POS_IO_BASE + 3*k + 1],
					chain_r[`BSR_POS_IO_BASE + 3*k + 2]};
			upd_in_only_r  <= chain_r[`BSR_POS_IN_ONLY];
			upd_out_only_r <= chain_r[`BSR_POS_OUT_ONLY];
			upd_tdo_t_r    <= chain_r[`BSR_POS_TDO_T];
			upd_tdo_o_r    <= chain_r[`BSR_POS_TDO_O];
		end
	end

	// =========================================
	// Test data out, changed on a falling test clock, cleared while the port is disabled
	logic tdo_nxt;

	always_comb begin
		tdo_nxt = bypass_r;
		if (state == bsr_pkg::TAP_SHIFT_IR)
			tdo_nxt = ir_shift_r[0];
		else
			case (instr)
				bsr_pkg::INS_EXTEST:    tdo_nxt = chain_r[0];
				bsr_pkg::INS_SAMPLE:    tdo_nxt = chain_r[0];
				bsr_pkg::INS_USER_ONE:  tdo_nxt = user_scan_out_one;
				bsr_pkg::INS_USER_TWO:  tdo_nxt = user_scan_out_two;
				bsr_pkg::INS_READBACK:  tdo_nxt = readback_data;
				bsr_pkg::INS_CONFIGURE: tdo_nxt = config_dout;
				default:                tdo_nxt = bypass_r;
			endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !tap_en) begin
			tdo_pin_out <= 1'b0;
			tdo_pin_oe  <= 1'b0;
		end else if (tck_fall) begin
			tdo_pin_out <= tdo_nxt;
			tdo_pin_oe  <= (state == bsr_pkg::TAP_SHIFT_IR)
				|| (state == bsr_pkg::TAP_SHIFT_DR);
		end
	end

	// =========================================
	// Pad and core muxing
	logic extest_on;
	logic config_on;

	assign extest_on = tap_en && instr == bsr_pkg::INS_EXTEST;
	assign config_on = tap_en && instr == bsr_pkg::INS_CONFIGURE;

	// Unconfigured outputs float; extest overrides that for testing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_pad_out   <= '0;
			io_pad_oe    <= '0;
			io_core_in   <= '0;
			out_only_pad <= 1'b0;
			in_only_core <= 1'b0;
			gclk_core    <= 1'b0;
		end else begin
			for (int k = 0; k < NIO; k++) begin
				if (extest_on) begin
					io_pad_out[k] <= upd_r[k].dout;
					io_pad_oe[k]  <= upd_r[k].tri_en;
				end else if (config_on || !cfg_done) begin
					io_pad_out[k] <= 1'b0;
					io_pad_oe[k]  <= 1'b0;
				end else begin
					io_pad_out[k] <= io_core_out[k];
					io_pad_oe[k]  <= io_core_oe[k];
				end
				// Clock pad used as clock keeps its pad value
				if (extest_on && !(k == `BSR_CLK_IO
					&& ctrl_r[`BSR_CTRL_CLKPAD]))
					io_core_in[k] <= upd_r[k].din;
				else
					io_core_in[k] <= pad_in_s[k];
			end
			out_only_pad <= extest_on ? upd_out_only_r : out_only_core;
			in_only_core <= extest_on ? upd_in_only_r : in_only_s;
			gclk_core    <= gclk_s;
		end
	end

	// Pulls are untouched by scan activity
	always_ff @(posedge aclk) begin
		if (!aresetn || !cfg_done) begin
			io_pull_up <= '1;
			io_pull_dn <= '0;
		end else begin
			io_pull_up <= {NIO{~ctrl_r[`BSR_CTRL_PULLDN]}};
			io_pull_dn <= {NIO{ctrl_r[`BSR_CTRL_PULLDN]}};
		end
	end

	// TAP pins: inputs always straight from the pad, drivers off in scan
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tap_pin_oe      <= '0;
			tap_pin_user_in <= '0;
		end else begin
			tap_pin_oe      <= tap_en ? 3'h0 : tap_pin_user_oe;
			tap_pin_user_in <= {tdi_s, tck_s, tms_s};
		end
	end

	// =========================================
	// User and configuration hooks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			user_select_one <= 1'b0;
			user_select_two <= 1'b0;
			user_dr_clock   <= 1'b0;
			user_idle_gate  <= 1'b1;
			user_reset      <= 1'b0;
			user_update     <= 1'b0;
			user_shift      <= 1'b0;
			user_tdi        <= 1'b0;
			readback_sel    <= 1'b0;
			config_sel      <= 1'b0;
		end else begin
			user_select_one <= instr == bsr_pkg::INS_USER_ONE;
			user_select_two <= instr == bsr_pkg::INS_USER_TWO;
			user_dr_clock   <= tck_s && (state == bsr_pkg::TAP_CAPTURE_DR
				|| state == bsr_pkg::TAP_SHIFT_DR);
			user_idle_gate  <= ~(tck_s && state == bsr_pkg::TAP_IDLE);
			user_reset      <= state == bsr_pkg::TAP_RESET;
			user_update     <= state == bsr_pkg::TAP_UPDATE_DR;
			user_shift      <= state == bsr_pkg::TAP_SHIFT_DR;
			user_tdi        <= tdi_s;
			readback_sel    <= instr == bsr_pkg::INS_READBACK;
			config_sel      <= config_on;
		end
	end

	// =========================================
	// AXI4-Lite write channel; address and data taken in either order
	logic [3:0] aw_addr_r;
	logic       aw_full_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic       w_full_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r     <= 1'b0;
			w_full_r      <= 1'b0;
			aw_addr_r     <= 4'h0;
			w_data_r      <= 32'h0;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BSR_RESP_OKAY;
			ctrl_r        <= `BSR_CTRL_RESET;
		end else begin
			s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r <= s_axi_awaddr;
				aw_full_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				w_full_r <= 1'b1;
			end
			if (aw_full_r && w_full_r && !s_axi_bvalid) begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_r == `BSR_ADDR_CTRL) begin
					s_axi_bresp <= `BSR_RESP_OKAY;
					if (w_strb_r[0])
						ctrl_r <= w_data_r[3:0];
				end else if (aw_addr_r == `BSR_ADDR_STATUS) begin
					s_axi_bresp <= `BSR_RESP_OKAY;
				end else begin
					s_axi_bresp <= `BSR_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `BSR_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= 32'h0;
				s_axi_rresp  <= `BSR_RESP_OKAY;
				if (s_axi_araddr == `BSR_ADDR_CTRL) begin
					s_axi_rdata[3:0] <= ctrl_r;
				end else if (s_axi_araddr == `BSR_ADDR_STATUS) begin
					s_axi_rdata[`BSR_STAT_STATE +: 4] <= state;
					s_axi_rdata[`BSR_STAT_INSTR +: 3] <= instr_r;
					s_axi_rdata[`BSR_STAT_TAPEN]      <= tap_en;
				end else begin
					s_axi_rresp <= `BSR_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

//--- bsr_top_asserts.sv
`timescale 1ns/100ps
`include "bsr_defs.svh"
// ==========
// Output relations of the scan port
module bsr_top_asserts (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   tdo_pin_oe,
	input wire logic [`BSR_NUM_IO-1:0] io_pad_oe,
	input wire logic                   gclk_pad,
	input wire logic                   gclk_core,
	input wire logic                   user_select_one,
	input wire logic                   user_select_two,
	input wire logic                   user_idle_gate,
	input wire logic                   user_reset,
	input wire logic                   user_update,
	input wire logic                   user_shift,
	input wire logic                   readback_sel,
	input wire logic                   config_sel
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Decodes of the instruction never overlap; configure keeps the I/O pads undriven
	chk_sel_pair: assert property (user_select_one |-> !user_select_two)
		else $error("both user selects high");
	chk_rb_excl: assert property (
		readback_sel |-> !user_select_one && !user_select_two)
		else $error("readback with user select");
	chk_cfg_excl: assert property (config_sel |-> !readback_sel)
		else $error("configure with readback");
	chk_cfg_pads: assert property (
		config_sel && $past(config_sel) |-> io_pad_oe == '0)
		else $error("pads driven under configure");
	// Clock pad bypasses scan data; TAP state decodes stay consistent
	chk_gclk_direct: assert property (
		$rose(gclk_core) |-> $past(gclk_pad, 3))
		else $error("clock core rose without pad");
	chk_idle_nand: assert property (
		$fell(user_idle_gate) |-> !user_shift && !user_update)
		else $error("idle gate low outside idle");
	chk_reset_quiet: assert property (user_reset |-> !tdo_pin_oe)
		else $error("tdo driven in reset");
	chk_shift_excl: assert property (
		user_shift |-> !user_update && !user_reset)
		else $error("state decodes overlap");
endmodule
bind bsr_top bsr_top_asserts bsr_top_asserts_inst (.*);

//--- testbench.sv
`timescale 1ns/100ps
`include "bsr_defs.svh"
module testbench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, tck_pin, tms_pin;
	logic        tdi_pin, tdo_pin_out, tdo_pin_oe, in_only_pad, in_only_core;
	logic        out_only_core, out_only_pad, gclk_pad, gclk_core;
	logic        user_select_one, user_select_two, user_scan_out_one;
	logic        user_scan_out_two, user_dr_clock, user_idle_gate, user_reset;
	logic        user_update, user_shift, user_tdi, readback_data, config_dout;
	logic        readback_sel, config_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  tap_pin_user_oe, tap_pin_oe, tap_pin_user_in;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, io_pad_in;
	logic [3:0]  io_pad_out, io_pad_oe, io_pull_up, io_pull_dn, io_core_out;
	logic [3:0]  io_core_oe, io_core_in;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	int          miscompares = 0;
	int          n_compared = 0;
	bsr_top bsr_top_inst (.*);
	bsr_jtag_host bsr_jtag_host_inst (.tck(tck_pin), .tms(tms_pin),
		.tdi(tdi_pin), .tdo(tdo_pin_out));
	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Master keeps each channel up until its own ready
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		{d, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'h0;
	endtask
	// Idle to Idle scans; returned bits are those seen in the shift state
	task automatic ir(input logic [2:0] c, output logic [31:0] q);
		bsr_jtag_host_inst.xfer(32'hc3, {25'h0, c, 4'h0}, 9, q);
	endtask
	task automatic dr(input logic [31:0] d, input int n,
		output logic [31:0] q);
		bsr_jtag_host_inst.xfer(32'h1 | (32'h3 << (n + 2)), d << 3, n + 5, q);
		q = q >> 3;
	endtask
	// ==========
	// Scenarios
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		chk({io_pull_up, tap_pin_oe}, 7'h78);
		axr(`BSR_ADDR_CTRL, d, r);
		chk(d, 32'h0);
		axw(4'h8, 32'h1, r);
		chk(r, `BSR_RESP_SLVERR);
		axr(4'hc, d, r);
		chk(r, `BSR_RESP_SLVERR);
		bsr_jtag_host_inst.xfer(32'h1f, 32'h0, 6, d);
		axr(`BSR_ADDR_STATUS, d, r);
		chk(d, 32'hf1);
	endtask
	task automatic t_instr;
		logic [31:0] q;
		logic [3:0]  e;
		for (int c = 0; c < 8; c++) begin
			ir(c[2:0], q);
			chk(q[6:4], `BSR_IR_CAPTURE);
			e = {c == 2, c == 3, c == 4, c == 5};
			chk({user_select_one, user_select_two, readback_sel,
				config_sel}, e);
			dr(32'h6, 4, q);
			e = (c == 2 || c == 4) ? 4'hf : (c > 5 ? 4'hc : 4'h0);
			if (c > 1) chk(q[3:0], e);
		end
	endtask
	// Capture under sample, preload a drive pattern, then apply it
	task automatic t_chain;
		logic [31:0] q, p, e;
		p = '0;
		e = '0;
		for (int k = 0; k < 4; k++) begin
			// Unconfigured pads float, so their out and 3-state capture low
			e[2 + 3 * k +: 3] = {io_pad_in[k], 2'h0};
			p[2 + 3 * k +: 3] = {k == 1 || k == 2, k == 0 || k == 3, 1'h1};
		end
		e[16:14] = {1'h0, out_only_core, in_only_pad};
		ir(3'h1, q);
		dr(p, 17, q);
		chk(q[16:2], e[16:2]);
		ir(3'h0, q);
		repeat (4) @(posedge aclk);
		chk({io_pad_oe, io_pad_out, io_core_in}, 12'hf96);
		chk({out_only_pad, gclk_core}, 2'h1);
		@(posedge aclk) io_pad_in <= 4'h5;
		dr(p, 17, q);
		chk({q[13], q[10], q[7], q[4]}, 4'h5);
	endtask
	task automatic t_config;
		logic [31:0] d;
		logic [1:0]  r;
		axw(`BSR_ADDR_CTRL, 32'hb, r);
		repeat (2) @(posedge aclk);
		chk({io_pull_up, io_pull_dn}, 8'h0f);
		ir(3'h7, d);
		chk({io_pad_oe, io_pad_out}, 8'h36);
		axw(`BSR_ADDR_CTRL, 32'h1, r);
		repeat (4) @(posedge aclk);
		axr(`BSR_ADDR_STATUS, d, r);
		chk({d[7], tdo_pin_oe, tap_pin_oe}, 5'h5);
	endtask
	// ==========
	// Clock, watchdog and main sequence
	initial begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		#1000000;
		miscompares++;
		conclude;
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, user_scan_out_two, config_dout, aresetn} = '0;
		{user_scan_out_one, readback_data, in_only_pad, gclk_pad} = '1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		tap_pin_user_oe = 3'h5;
		io_pad_in = 4'ha;
		io_core_out = 4'h6;
		io_core_oe = 4'h3;
		out_only_core = 1'h1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs;
		t_instr;
		t_chain;
		t_config;
		conclude;
	end
endmodule
